// ---- design/osc_ctl_pkg.sv ----
// constants for the oscillator control block
// assumes a single 50 MHz system clock and a plain register port
package osc_ctl_pkg;
    localparam int          ADDR_W          = 4;
    localparam logic [3:0]  OSC_CTL_ADDR    = 4'h0;
    localparam logic [3:0]  IRQ_STAT_ADDR   = 4'h1;
    localparam logic [3:0]  IRQ_MASK_ADDR   = 4'h2;
    localparam logic [3:0]  LOCK_STAT_ADDR  = 4'h3;
    localparam logic [7:0]  UNLOCK_FIRST    = 8'hE7;
    localparam logic [7:0]  UNLOCK_SECOND   = 8'h18;
    localparam logic [7:0]  OSC_CTL_RESET   = 8'h00;
    localparam int          SEL_LSB         = 0;
    localparam int          FAIL_EN_BIT     = 5;
    localparam int          IPO_EN_BIT      = 7;
    localparam int          XTAL_EN_BIT     = 6;
    localparam logic [2:0]  SEL_IPO_FAST    = 3'h0;
    localparam logic [2:0]  SEL_IPO_SLOW    = 3'h1;
    localparam logic [2:0]  SEL_XTAL        = 3'h2;
    localparam logic [2:0]  SEL_WDOG        = 3'h3;
    localparam logic [2:0]  SEL_EXT_PIN     = 3'h4;
    localparam int          EV_ACCEPT       = 0;
    localparam int          EV_REJECT       = 1;
    localparam int          EV_RESERVED     = 2;
    localparam int          EV_W            = 3;
endpackage

// ---- design/unlock_seq.sv ----
// unlock sequencer: watches control-register writes only
// assumes one write strobe per cycle, synchronous reset
`timescale 1ns/1ns
`default_nettype none
module unlock_seq (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       ctl_wr,
    input  wire logic [7:0] wdata,
    output logic            accept,
    output logic [1:0]      stage
);
    typedef enum logic [1:0] {LOCKED, HALF, OPEN} lock_t;
    lock_t state_reg;
    lock_t state_next;

    always_comb begin
        state_next = state_reg;
        accept     = 1'b0;
        case (state_reg)
            LOCKED: begin
                if (ctl_wr && wdata == osc_ctl_pkg::UNLOCK_FIRST) begin
                    state_next = HALF;
                end
            end
            HALF: begin
                if (ctl_wr) begin
                    state_next = (wdata == osc_ctl_pkg::UNLOCK_SECOND) ? OPEN : LOCKED;
                end
            end
            OPEN: begin
                if (ctl_wr) begin
                    accept     = 1'b1;
                    state_next = LOCKED;
                end
            end
            default: state_next = LOCKED;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= LOCKED;
        end else begin
            state_reg <= state_next;
        end
    end

    assign stage = state_reg;
endmodule
`default_nettype wire

// ---- design/clk_source_decode.sv ----
// decodes the source selector into one-hot source enables
// assumes the selector comes from a register
`timescale 1ns/1ns
`default_nettype none
module clk_source_decode (
    input  wire logic [2:0] sel,
    output logic [4:0]      onehot,
    output logic            reserved
);
    always_comb begin
        onehot   = 5'h00;
        reserved = 1'b0;
        case (sel)
            osc_ctl_pkg::SEL_IPO_FAST: onehot = 5'h01;
            osc_ctl_pkg::SEL_IPO_SLOW: onehot = 5'h02;
            osc_ctl_pkg::SEL_XTAL:     onehot = 5'h04;
            osc_ctl_pkg::SEL_WDOG:     onehot = 5'h08;
            osc_ctl_pkg::SEL_EXT_PIN:  onehot = 5'h10;
            default:                   reserved = 1'b1;
        endcase
    end
endmodule
`default_nettype wire

// ---- design/osc_ctl.sv ----
// oscillator control block with write-protected control register
// assumes the register port is synchronous to mclk; reads answer next cycle
`timescale 1ns/1ns
`default_nettype none
module osc_ctl (
    input  wire logic                            mclk,
    input  wire logic                            rst,
    input  wire logic [osc_ctl_pkg::ADDR_W-1:0]  addr,
    input  wire logic [7:0]                      wdata,
    input  wire logic                            wr,
    input  wire logic                            rd,
    output logic [7:0]                           rdata,
    output logic [2:0]                           sys_clock_source_sel,
    output logic [4:0]                           source_onehot,
    output logic                                 ipo_enable,
    output logic                                 xtal_enable,
    output logic                                 watchdog_osc_fail_detect_en,
    output logic                                 irq
);
    logic [7:0]           ctl_reg;
    logic [osc_ctl_pkg::EV_W-1:0] stat_reg;
    logic [osc_ctl_pkg::EV_W-1:0] mask_reg;
    logic [osc_ctl_pkg::EV_W-1:0] ev;
    logic [4:0]           onehot;
    logic                 reserved;
    logic                 accept;
    logic [1:0]           stage;
    logic                 ctl_wr;
    logic [2:0]           sel_in;

    // only control-register writes feed the sequencer
    assign ctl_wr = wr && addr == osc_ctl_pkg::OSC_CTL_ADDR;
    assign sel_in = wdata[osc_ctl_pkg::SEL_LSB +: 3];

    unlock_seq u_seq (
        .mclk   (mclk),
        .rst    (rst),
        .ctl_wr (ctl_wr),
        .wdata  (wdata),
        .accept (accept),
        .stage  (stage)
    );

    clk_source_decode u_dec (
        .sel      (ctl_reg[osc_ctl_pkg::SEL_LSB +: 3]),
        .onehot   (onehot),
        .reserved (reserved)
    );

    // load on accepted write, else hold
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctl_reg <= osc_ctl_pkg::OSC_CTL_RESET;
        end else if (accept) begin
            ctl_reg <= wdata;
        end
    end

    assign ev[osc_ctl_pkg::EV_ACCEPT]   = accept;
    assign ev[osc_ctl_pkg::EV_REJECT]   = ctl_wr && !accept && stage == 2'd1
                                          && wdata != osc_ctl_pkg::UNLOCK_SECOND;
    assign ev[osc_ctl_pkg::EV_RESERVED] = accept && sel_in > osc_ctl_pkg::SEL_EXT_PIN;

    // sticky status: set wins over write-one-to-clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            stat_reg <= '0;
        end else if (wr && addr == osc_ctl_pkg::IRQ_STAT_ADDR) begin
            stat_reg <= (stat_reg & ~wdata[osc_ctl_pkg::EV_W-1:0]) | ev;
        end else begin
            stat_reg <= stat_reg | ev;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            mask_reg <= '0;
        end else if (wr && addr == osc_ctl_pkg::IRQ_MASK_ADDR) begin
            mask_reg <= wdata[osc_ctl_pkg::EV_W-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((stat_reg & ~(wr && addr == osc_ctl_pkg::IRQ_STAT_ADDR
                      ? wdata[osc_ctl_pkg::EV_W-1:0] : 3'h0)) | ev) & mask_reg);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sys_clock_source_sel        <= 3'h0;
            source_onehot               <= 5'h01;
            ipo_enable                  <= 1'b0;
            xtal_enable                 <= 1'b0;
            watchdog_osc_fail_detect_en <= 1'b0;
        end else begin
            sys_clock_source_sel        <= ctl_reg[osc_ctl_pkg::SEL_LSB +: 3];
            source_onehot               <= reserved ? source_onehot : onehot;
            ipo_enable                  <= ctl_reg[osc_ctl_pkg::IPO_EN_BIT];
            xtal_enable                 <= ctl_reg[osc_ctl_pkg::XTAL_EN_BIT];
            watchdog_osc_fail_detect_en <= ctl_reg[osc_ctl_pkg::FAIL_EN_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (rd) begin
            case (addr)
                osc_ctl_pkg::OSC_CTL_ADDR:   rdata <= ctl_reg;
                osc_ctl_pkg::IRQ_STAT_ADDR:  rdata <= {5'h00, stat_reg};
                osc_ctl_pkg::IRQ_MASK_ADDR:  rdata <= {5'h00, mask_reg};
                osc_ctl_pkg::LOCK_STAT_ADDR: rdata <= {6'h00, stage};
                default:                     rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    relock_a: assert property (@(posedge mclk) disable iff (rst)
        accept |=> stage == 2'd0 && ctl_reg == $past(wdata)) else $error("no relock after data write");
    hold_ctl_a: assert property (@(posedge mclk) disable iff (rst)
        !accept |=> $stable(ctl_reg)) else $error("control changed while locked");
    // second value arms only from first
    unlock_pair_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(stage == 2'd2) |-> $past(ctl_wr) && $past(wdata) == osc_ctl_pkg::UNLOCK_SECOND
        && $past(stage) == 2'd1) else $error("unlock without pair");
    other_keep_a: assert property (@(posedge mclk) disable iff (rst)
        !ctl_wr |=> $stable(stage)) else $error("progress lost on other access");
    gap_keep_a: assert property (@(posedge mclk) disable iff (rst)
        (stage == 2'd1 && !ctl_wr) [*2] |=> stage == 2'd1) else $error("half unlock dropped");
    fail_en_a: assert property (@(posedge mclk) disable iff (rst)
        accept |=> ##1 watchdog_osc_fail_detect_en == ctl_reg[5]) else $error("fail detect mismatch");
    sel_fast_a: assert property (@(posedge mclk) disable iff (rst)
        ctl_reg[2:0] == 3'h0 |=> source_onehot == 5'h01) else $error("fast select wrong");
    sel_ext_a: assert property (@(posedge mclk) disable iff (rst)
        ctl_reg[2:0] == 3'h4 |=> source_onehot == 5'h10) else $error("pin select wrong");
    sel_wdog_a: assert property (@(posedge mclk) disable iff (rst)
        ctl_reg[2:0] == 3'h3 |=> source_onehot == 5'h08) else $error("watchdog select wrong");
    reset_lock_a: assert property (@(posedge mclk)
        rst |=> stage == 2'd0) else $error("reset left unlock progress");
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking bench for the oscillator control block
// assumes osc_ctl_pkg and the design files are compiled before it
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic                           mclk;
    logic                           rst;
    logic [osc_ctl_pkg::ADDR_W-1:0] addr;
    logic [7:0]                     wdata;
    logic                           wr;
    logic                           rd;
    logic [7:0]                     rdata;
    logic [2:0]                     sys_clock_source_sel;
    logic [4:0]                     source_onehot;
    logic                           ipo_enable;
    logic                           xtal_enable;
    logic                           watchdog_osc_fail_detect_en;
    logic                           irq;
    int                             err_total = 0;
    int                             samples_checked = 0;
    int                             cycle_cnt = 0;
    int                             i;

    osc_ctl osc_ctl_inst (
        .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .sys_clock_source_sel(sys_clock_source_sel), .source_onehot(source_onehot),
        .ipo_enable(ipo_enable), .xtal_enable(xtal_enable),
        .watchdog_osc_fail_detect_en(watchdog_osc_fail_detect_en), .irq(irq)
    );

    initial mclk = 1'b0;
    always #10 mclk = ~mclk;

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // hang guard, runs far longer than the tests need
    always @(posedge mclk) begin
        cycle_cnt <= cycle_cnt + 1;
        if (cycle_cnt == 3000) begin
            err_total++;
            $display("[FAIL] %0t timeout", $time);
            report_and_stop();
        end
    end

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        cmp(rdata, exp);
        @(posedge mclk);
    endtask

    task automatic wr_ctl(input logic [7:0] d);
        wr_reg(osc_ctl_pkg::OSC_CTL_ADDR, d);
    endtask

    task automatic unlock_wr(input logic [7:0] d);
        wr_ctl(osc_ctl_pkg::UNLOCK_FIRST);
        wr_ctl(osc_ctl_pkg::UNLOCK_SECOND);
        wr_ctl(d);
    endtask

    // en is {ipo, crystal, fail detect}; outputs lag the register by a cycle
    task automatic chk_out(input logic [2:0] s, input logic [4:0] oh, input logic [2:0] en, input logic q);
        repeat (2) @(posedge mclk);
        #1;
        cmp({5'h00, sys_clock_source_sel}, {5'h00, s});
        cmp({3'h0, source_onehot}, {3'h0, oh});
        cmp({5'h00, ipo_enable, xtal_enable, watchdog_osc_fail_detect_en}, {5'h00, en});
        cmp({7'h00, irq}, {7'h00, q});
    endtask

    initial begin
        rst = 1'b1;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd_reg(osc_ctl_pkg::OSC_CTL_ADDR, 8'h00);
        chk_out(3'h0, 5'h01, 3'h0, 1'b0);
        rd_reg(4'h8, 8'h00);
        wr_reg(osc_ctl_pkg::IRQ_MASK_ADDR, 8'h07);
        rd_reg(osc_ctl_pkg::IRQ_MASK_ADDR, 8'h07);
        $display("test reset done");
        // unlock steps spread out with other accesses between them
        wr_ctl(8'hE7);
        rd_reg(osc_ctl_pkg::IRQ_STAT_ADDR, 8'h00);
        wr_reg(osc_ctl_pkg::IRQ_MASK_ADDR, 8'h07);
        wr_ctl(8'h18);
        wr_reg(4'h9, 8'hFF);
        wr_ctl(8'hA2);
        rd_reg(osc_ctl_pkg::OSC_CTL_ADDR, 8'hA2);
        chk_out(3'h2, 5'h04, 3'h5, 1'b1);
        wr_ctl(8'h00);
        rd_reg(osc_ctl_pkg::OSC_CTL_ADDR, 8'hA2);
        rd_reg(osc_ctl_pkg::IRQ_STAT_ADDR, 8'h01);
        wr_reg(osc_ctl_pkg::IRQ_STAT_ADDR, 8'h01);
        chk_out(3'h2, 5'h04, 3'h5, 1'b0);
        $display("test unlock done");
        for (i = 0; i < 5; i++) begin
            unlock_wr({2'b01, i[0], 2'b00, i[2:0]});
            chk_out(i[2:0], 5'h01 << i, {2'b01, i[0]}, 1'b1);
        end
        unlock_wr(8'h85);
        wr_reg(osc_ctl_pkg::IRQ_STAT_ADDR, 8'h01);
        rd_reg(osc_ctl_pkg::IRQ_STAT_ADDR, 8'h04);
        rd_reg(osc_ctl_pkg::OSC_CTL_ADDR, 8'h85);
        chk_out(3'h5, 5'h10, 3'h4, 1'b1);
        $display("test selector done");
        wr_reg(osc_ctl_pkg::IRQ_STAT_ADDR, 8'h07);
        wr_reg(osc_ctl_pkg::IRQ_MASK_ADDR, 8'h02);
        wr_ctl(8'h18);
        wr_ctl(8'hE7);
        wr_ctl(8'h03);
        wr_ctl(8'h18);
        wr_ctl(8'h01);
        wr_ctl(8'hE7);
        wr_ctl(8'hE7);
        wr_ctl(8'h18);
        wr_ctl(8'h02);
        rd_reg(osc_ctl_pkg::OSC_CTL_ADDR, 8'h85);
        rd_reg(osc_ctl_pkg::IRQ_STAT_ADDR, 8'h02);
        chk_out(3'h5, 5'h10, 3'h4, 1'b1);
        wr_reg(osc_ctl_pkg::IRQ_MASK_ADDR, 8'h05);
        chk_out(3'h5, 5'h10, 3'h4, 1'b0);
        $display("test bad order done");
        wr_ctl(8'hE7);
        wr_ctl(8'h18);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        wr_ctl(8'h83);
        rd_reg(osc_ctl_pkg::OSC_CTL_ADDR, 8'h00);
        unlock_wr(8'h83);
        rd_reg(osc_ctl_pkg::OSC_CTL_ADDR, 8'h83);
        chk_out(3'h3, 5'h08, 3'h4, 1'b0);
        $display("test reset relock done");
        report_and_stop();
    end
endmodule
`default_nettype wire
